// ==== pcw_defines.vh ====
// Constants of the PIP / cursor / canvas / active window register bank.
// Assumes byte-wide host register offsets on an 8-bit index.
`ifndef PCW_DEFINES_VH
`define PCW_DEFINES_VH

// Register offsets
`define PCW_OFF_PIP_Y_LO 8'h36
`define PCW_OFF_PIP_Y_HI 8'h37
`define PCW_OFF_PIP_W_LO 8'h38
`define PCW_OFF_PIP_W_HI 8'h39
`define PCW_OFF_PIP_H_LO 8'h3a
`define PCW_OFF_PIP_H_HI 8'h3b
`define PCW_OFF_CTRL 8'h3c
`define PCW_OFF_BLINK 8'h3d
`define PCW_OFF_TCUR_W 8'h3e
`define PCW_OFF_TCUR_H 8'h3f
`define PCW_OFF_GCUR_X_LO 8'h40
`define PCW_OFF_GCUR_X_HI 8'h41
`define PCW_OFF_GCUR_Y_LO 8'h42
`define PCW_OFF_GCUR_Y_HI 8'h43
`define PCW_OFF_GCOL_A 8'h44
`define PCW_OFF_GCOL_B 8'h45
`define PCW_OFF_CVS_B0 8'h50
`define PCW_OFF_CVS_B1 8'h51
`define PCW_OFF_CVS_B2 8'h52
`define PCW_OFF_CVS_B3 8'h53
`define PCW_OFF_CVS_W_LO 8'h54
`define PCW_OFF_CVS_W_HI 8'h55
`define PCW_OFF_AW_X_LO 8'h56
`define PCW_OFF_AW_X_HI 8'h57
`define PCW_OFF_AW_Y_LO 8'h58
`define PCW_OFF_AW_Y_HI 8'h59
`define PCW_OFF_AW_W_LO 8'h5a
`define PCW_OFF_AW_W_HI 8'h5b

// Control register fields
`define PCW_CTRL_GAMMA_EN 7
`define PCW_CTRL_GTAB_HI 6
`define PCW_CTRL_GTAB_LO 5
`define PCW_CTRL_GCUR_EN 4
`define PCW_CTRL_GSET_HI 3
`define PCW_CTRL_GSET_LO 2
`define PCW_CTRL_TCUR_EN 1
`define PCW_CTRL_BLINK_EN 0
`define PCW_GTAB_NONE 2'h3

// Reset values
`define PCW_RST_BYTE 8'h00
`define PCW_RST_TCUR_W 5'h07
`define PCW_RST_TCUR_H 5'h00

// Field widths of the upper bytes; PIP width step of eight pixels
`define PCW_HI13_MASK 8'h1f
`define PCW_HI14_MASK 8'h3f
`define PCW_HSTEP_MASK 14'h3ff8

`endif

// ==== pcw_regs.v ====
// Byte-wide host register bank: PIP window geometry, gamma and cursor
// control, graphic cursor, canvas and active window geometry.
// Assumes the host link decodes into single-cycle byte read/write strobes on clk,
// and that window select, scan direction, addressing mode, enlargement and
// frame tick come from logic on the same clock.
`include "pcw_defines.vh"
`default_nettype none

module pcw_regs (
    // Clock and reset
    input wire clk,
    input wire rstn,
    // Host register port
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_we,
    input wire reg_re,
    output reg [7:0] reg_rdata,
    // Controller state
    input wire pip_window_select,
    input wire vertical_scan_direction,
    input wire canvas_linear_mode,
    input wire [1:0] char_enlarge,
    input wire frame_tick,
    // PIP geometry
    output reg [12:0] pip1_origin_y,
    output reg [13:0] pip1_width,
    output reg [13:0] pip1_height,
    output reg [12:0] pip2_origin_y,
    output reg [13:0] pip2_width,
    output reg [13:0] pip2_height,
    // Gamma
    output reg gamma_enable,
    output reg [1:0] gamma_table_sel,
    output reg gamma_table_valid,
    // Cursors
    output reg graphic_cursor_on,
    output reg [1:0] graphic_cursor_set,
    output reg text_cursor_on,
    output reg text_cursor_visible,
    output reg [7:0] text_cursor_width_px,
    output reg [7:0] text_cursor_height_px,
    output reg [12:0] graphic_cursor_x_pos,
    output reg [12:0] graphic_cursor_y_pos,
    output reg [7:0] cursor_colour_a,
    output reg [7:0] cursor_colour_b,
    // Canvas and active window
    output reg [31:0] canvas_base,
    output reg [13:0] canvas_width,
    output reg [12:0] aw_origin_x,
    output reg [12:0] aw_origin_y,
    output reg [13:0] aw_width
);

    // Stored registers; index 0 is PIP set 1, index 1 is set 2
    reg [12:0] pip_y_ff [0:1];
    reg [13:0] pip_w_ff [0:1];
    reg [13:0] pip_h_ff [0:1];
    reg [7:0] stage_y_ff;
    reg [7:0] stage_w_ff;
    reg [7:0] stage_h_ff;
    reg [7:0] ctrl_ff;
    reg [7:0] blink_ff;
    reg [4:0] tcur_w_ff;
    reg [4:0] tcur_h_ff;
    reg [12:0] gcur_x_ff;
    reg [12:0] gcur_y_ff;
    reg [7:0] gcol_a_ff;
    reg [7:0] gcol_b_ff;
    reg [31:0] cvs_base_ff;
    reg [13:0] cvs_w_ff;
    reg [12:0] aw_x_ff;
    reg [12:0] aw_y_ff;
    reg [13:0] aw_w_ff;
    reg [7:0] blink_cnt_ff;
    reg blink_phase_ff;
    reg [7:0] nxt_rdata;
    reg [7:0] nxt_blink_cnt;
    reg nxt_blink_phase;
    // Next values of the display-side outputs
    reg nxt_gcur_on;
    reg nxt_tcur_on;
    reg nxt_tcur_visible;
    reg nxt_gtab_valid;
    reg [7:0] nxt_tcur_w_px;
    reg [7:0] nxt_tcur_h_px;
    reg [31:0] nxt_canvas_base;
    reg [13:0] nxt_canvas_width;
    reg [12:0] nxt_aw_x;
    reg [12:0] nxt_aw_y;
    reg [13:0] nxt_aw_w;

    wire sel = pip_window_select;
    wire [2:0] scale = {1'b0, char_enlarge} + 3'h1;
    wire gcur_active = ctrl_ff[`PCW_CTRL_GCUR_EN] & ~vertical_scan_direction;

    // Register writes
    integer i;
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            for (i = 0; i < 2; i = i + 1) begin
                pip_y_ff[i] <= 13'h0000;
                pip_w_ff[i] <= 14'h0000;
                pip_h_ff[i] <= 14'h0000;
            end
            stage_y_ff <= `PCW_RST_BYTE;
            stage_w_ff <= `PCW_RST_BYTE;
            stage_h_ff <= `PCW_RST_BYTE;
            ctrl_ff <= `PCW_RST_BYTE;
            blink_ff <= `PCW_RST_BYTE;
            tcur_w_ff <= `PCW_RST_TCUR_W;
            tcur_h_ff <= `PCW_RST_TCUR_H;
            gcur_x_ff <= 13'h0000;
            gcur_y_ff <= 13'h0000;
            gcol_a_ff <= `PCW_RST_BYTE;
            gcol_b_ff <= `PCW_RST_BYTE;
            cvs_base_ff <= 32'h0000_0000;
            cvs_w_ff <= 14'h0000;
            aw_x_ff <= 13'h0000;
            aw_y_ff <= 13'h0000;
            aw_w_ff <= 14'h0000;
        end else if (reg_we) begin
            case (reg_addr)
                // Low bytes wait in staging until the high byte lands
                `PCW_OFF_PIP_Y_LO: stage_y_ff <= reg_wdata;
                `PCW_OFF_PIP_W_LO: stage_w_ff <= reg_wdata;
                `PCW_OFF_PIP_H_LO: stage_h_ff <= reg_wdata;
                // High bytes commit into the set picked by the window select
                `PCW_OFF_PIP_Y_HI: begin
                    pip_y_ff[sel] <= {reg_wdata[4:0], stage_y_ff};
                end
                `PCW_OFF_PIP_W_HI: begin
                    pip_w_ff[sel] <= {reg_wdata[5:0], stage_w_ff};
                end
                `PCW_OFF_PIP_H_HI: begin
                    pip_h_ff[sel] <= {reg_wdata[5:0], stage_h_ff};
                end
                `PCW_OFF_CTRL: ctrl_ff <= reg_wdata;
                `PCW_OFF_BLINK: blink_ff <= reg_wdata;
                `PCW_OFF_TCUR_W: tcur_w_ff <= reg_wdata[4:0];
                `PCW_OFF_TCUR_H: tcur_h_ff <= reg_wdata[4:0];
                `PCW_OFF_GCUR_X_LO: gcur_x_ff[7:0] <= reg_wdata;
                `PCW_OFF_GCUR_X_HI: gcur_x_ff[12:8] <= reg_wdata[4:0];
                `PCW_OFF_GCUR_Y_LO: gcur_y_ff[7:0] <= reg_wdata;
                `PCW_OFF_GCUR_Y_HI: gcur_y_ff[12:8] <= reg_wdata[4:0];
                `PCW_OFF_GCOL_A: gcol_a_ff <= reg_wdata;
                `PCW_OFF_GCOL_B: gcol_b_ff <= reg_wdata;
                `PCW_OFF_CVS_B0: cvs_base_ff[7:0] <= reg_wdata;
                `PCW_OFF_CVS_B1: cvs_base_ff[15:8] <= reg_wdata;
                `PCW_OFF_CVS_B2: cvs_base_ff[23:16] <= reg_wdata;
                `PCW_OFF_CVS_B3: cvs_base_ff[31:24] <= reg_wdata;
                `PCW_OFF_CVS_W_LO: cvs_w_ff[7:0] <= reg_wdata;
                `PCW_OFF_CVS_W_HI: cvs_w_ff[13:8] <= reg_wdata[5:0];
                `PCW_OFF_AW_X_LO: aw_x_ff[7:0] <= reg_wdata;
                `PCW_OFF_AW_X_HI: aw_x_ff[12:8] <= reg_wdata[4:0];
                `PCW_OFF_AW_Y_LO: aw_y_ff[7:0] <= reg_wdata;
                `PCW_OFF_AW_Y_HI: aw_y_ff[12:8] <= reg_wdata[4:0];
                `PCW_OFF_AW_W_LO: aw_w_ff[7:0] <= reg_wdata;
                `PCW_OFF_AW_W_HI: aw_w_ff[13:8] <= reg_wdata[5:0];
                default: ;
            endcase
        end
    end

    // Read mux; unused bits and unmapped offsets read zero
    // PIP offsets show the set picked by the window select
    always @* begin
        nxt_rdata = 8'h00;
        case (reg_addr)
            `PCW_OFF_PIP_Y_LO: nxt_rdata = pip_y_ff[sel][7:0];
            `PCW_OFF_PIP_Y_HI: nxt_rdata = {3'h0, pip_y_ff[sel][12:8]};
            `PCW_OFF_PIP_W_LO: nxt_rdata = pip_w_ff[sel][7:0];
            `PCW_OFF_PIP_W_HI: nxt_rdata = {2'h0, pip_w_ff[sel][13:8]};
            `PCW_OFF_PIP_H_LO: nxt_rdata = pip_h_ff[sel][7:0];
            `PCW_OFF_PIP_H_HI: nxt_rdata = {2'h0, pip_h_ff[sel][13:8]};
            `PCW_OFF_CTRL: nxt_rdata = ctrl_ff;
            `PCW_OFF_BLINK: nxt_rdata = blink_ff;
            `PCW_OFF_TCUR_W: nxt_rdata = {3'h0, tcur_w_ff};
            `PCW_OFF_TCUR_H: nxt_rdata = {3'h0, tcur_h_ff};
            `PCW_OFF_GCUR_X_LO: nxt_rdata = gcur_x_ff[7:0];
            `PCW_OFF_GCUR_X_HI: nxt_rdata = {3'h0, gcur_x_ff[12:8]};
            `PCW_OFF_GCUR_Y_LO: nxt_rdata = gcur_y_ff[7:0];
            `PCW_OFF_GCUR_Y_HI: nxt_rdata = {3'h0, gcur_y_ff[12:8]};
            `PCW_OFF_GCOL_A: nxt_rdata = gcol_a_ff;
            `PCW_OFF_GCOL_B: nxt_rdata = gcol_b_ff;
            `PCW_OFF_CVS_B0: nxt_rdata = cvs_base_ff[7:0];
            `PCW_OFF_CVS_B1: nxt_rdata = cvs_base_ff[15:8];
            `PCW_OFF_CVS_B2: nxt_rdata = cvs_base_ff[23:16];
            `PCW_OFF_CVS_B3: nxt_rdata = cvs_base_ff[31:24];
            `PCW_OFF_CVS_W_LO: nxt_rdata = cvs_w_ff[7:0];
            `PCW_OFF_CVS_W_HI: nxt_rdata = {2'h0, cvs_w_ff[13:8]};
            `PCW_OFF_AW_X_LO: nxt_rdata = aw_x_ff[7:0];
            `PCW_OFF_AW_X_HI: nxt_rdata = {3'h0, aw_x_ff[12:8]};
            `PCW_OFF_AW_Y_LO: nxt_rdata = aw_y_ff[7:0];
            `PCW_OFF_AW_Y_HI: nxt_rdata = {3'h0, aw_y_ff[12:8]};
            `PCW_OFF_AW_W_LO: nxt_rdata = aw_w_ff[7:0];
            `PCW_OFF_AW_W_HI: nxt_rdata = {2'h0, aw_w_ff[13:8]};
            default: nxt_rdata = 8'h00;
        endcase
    end

    // Blink timer: phase flips after setting plus one frames
    always @* begin
        nxt_blink_cnt = blink_cnt_ff;
        nxt_blink_phase = blink_phase_ff;
        if (!ctrl_ff[`PCW_CTRL_BLINK_EN]) begin
            nxt_blink_cnt = 8'h00;
            nxt_blink_phase = 1'b1;
        end else if (frame_tick) begin
            if (blink_cnt_ff >= blink_ff) begin
                nxt_blink_cnt = 8'h00;
                nxt_blink_phase = ~blink_phase_ff;
            end else begin
                nxt_blink_cnt = blink_cnt_ff + 8'h01;
            end
        end
    end

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            blink_cnt_ff <= 8'h00;
            blink_phase_ff <= 1'b1;
            reg_rdata <= 8'h00;
        end else begin
            blink_cnt_ff <= nxt_blink_cnt;
            blink_phase_ff <= nxt_blink_phase;
            // Read data only moves on a read strobe
            if (reg_re) begin
                reg_rdata <= nxt_rdata;
            end
        end
    end

    // Display-side values; the graphic cursor outranks the text cursor
    always @* begin
        nxt_gcur_on = gcur_active;
        nxt_tcur_on = ctrl_ff[`PCW_CTRL_TCUR_EN] & ~gcur_active;
        nxt_tcur_visible = nxt_tcur_on & blink_phase_ff;
        nxt_gtab_valid =
            ctrl_ff[`PCW_CTRL_GTAB_HI:`PCW_CTRL_GTAB_LO] != `PCW_GTAB_NONE;
        nxt_tcur_w_px = ({3'h0, tcur_w_ff} + 8'h01) * {5'h00, scale};
        nxt_tcur_h_px = ({3'h0, tcur_h_ff} + 8'h01) * {5'h00, scale};
        nxt_canvas_base = cvs_base_ff;
        nxt_canvas_width = cvs_w_ff;
        nxt_aw_x = aw_x_ff;
        nxt_aw_y = aw_y_ff;
        nxt_aw_w = aw_w_ff;
        // Linear addressing disables the canvas and window geometry
        if (canvas_linear_mode) begin
            nxt_canvas_base = 32'h0000_0000;
            nxt_canvas_width = 14'h0000;
            nxt_aw_x = 13'h0000;
            nxt_aw_y = 13'h0000;
            nxt_aw_w = 14'h0000;
        end
    end

    // Registered outputs toward the display and drawing paths
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pip1_origin_y <= 13'h0000;
            pip1_width <= 14'h0000;
            pip1_height <= 14'h0000;
            pip2_origin_y <= 13'h0000;
            pip2_width <= 14'h0000;
            pip2_height <= 14'h0000;
            gamma_enable <= 1'b0;
            gamma_table_sel <= 2'h0;
            gamma_table_valid <= 1'b0;
            graphic_cursor_on <= 1'b0;
            graphic_cursor_set <= 2'h0;
            text_cursor_on <= 1'b0;
            text_cursor_visible <= 1'b0;
            text_cursor_width_px <= 8'h00;
            text_cursor_height_px <= 8'h00;
            graphic_cursor_x_pos <= 13'h0000;
            graphic_cursor_y_pos <= 13'h0000;
            cursor_colour_a <= 8'h00;
            cursor_colour_b <= 8'h00;
            canvas_base <= 32'h0000_0000;
            canvas_width <= 14'h0000;
            aw_origin_x <= 13'h0000;
            aw_origin_y <= 13'h0000;
            aw_width <= 14'h0000;
        end else begin
            pip1_origin_y <= pip_y_ff[0];
            pip1_width <= pip_w_ff[0] & `PCW_HSTEP_MASK;
            pip1_height <= pip_h_ff[0];
            pip2_origin_y <= pip_y_ff[1];
            pip2_width <= pip_w_ff[1] & `PCW_HSTEP_MASK;
            pip2_height <= pip_h_ff[1];
            gamma_enable <= ctrl_ff[`PCW_CTRL_GAMMA_EN];
            gamma_table_sel <= ctrl_ff[`PCW_CTRL_GTAB_HI:`PCW_CTRL_GTAB_LO];
            gamma_table_valid <= nxt_gtab_valid;
            graphic_cursor_on <= nxt_gcur_on;
            graphic_cursor_set <= ctrl_ff[`PCW_CTRL_GSET_HI:`PCW_CTRL_GSET_LO];
            text_cursor_on <= nxt_tcur_on;
            text_cursor_visible <= nxt_tcur_visible;
            text_cursor_width_px <= nxt_tcur_w_px;
            text_cursor_height_px <= nxt_tcur_h_px;
            graphic_cursor_x_pos <= gcur_x_ff;
            graphic_cursor_y_pos <= gcur_y_ff;
            cursor_colour_a <= gcol_a_ff;
            cursor_colour_b <= gcol_b_ff;
            canvas_base <= nxt_canvas_base;
            canvas_width <= nxt_canvas_width;
            aw_origin_x <= nxt_aw_x;
            aw_origin_y <= nxt_aw_y;
            aw_width <= nxt_aw_w;
        end
    end

endmodule // pcw_regs

`default_nettype wire

// ==== pcw_regs_monitor.sv ====
// Concurrent checks on the port behaviour of the PIP / cursor / canvas bank.
// Assumes it is bound to pcw_regs and sees only that module's ports.
`include "pcw_defines.vh"
`default_nettype none

module pcw_regs_monitor (
    // Clock, reset and host port
    input wire logic clk,
    input wire logic rstn,
    input wire logic [7:0] reg_addr,
    input wire logic reg_we,
    input wire logic reg_re,
    input wire logic [7:0] reg_rdata,
    // Controller state and watched outputs
    input wire logic pip_window_select,
    input wire logic vertical_scan_direction,
    input wire logic canvas_linear_mode,
    input wire logic [13:0] pip1_width,
    input wire logic [13:0] pip2_width,
    input wire logic graphic_cursor_on,
    input wire logic text_cursor_on,
    input wire logic text_cursor_visible,
    input wire logic [31:0] canvas_base,
    input wire logic [13:0] canvas_width,
    input wire logic [13:0] aw_width
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking mc @(posedge clk); endclocking
    default disable iff (!rstn);
    // High byte writes that commit a PIP width into set one or two
    wire logic w1_hi = reg_we && reg_addr == `PCW_OFF_PIP_W_HI && !pip_window_select;
    wire logic w2_hi = reg_we && reg_addr == `PCW_OFF_PIP_W_HI && pip_window_select;

    a_width_step: assert property (pip1_width[2:0] == 3'b000 && pip2_width[2:0] == 3'b000)
        else $error("pip width not on an eight pixel step");
    a_width_commit: assert property ($changed(pip1_width) |-> $past(w1_hi) || $past(w1_hi, 2))
        else $error("pip1 width changed without a high byte write");
    a_select_steer: assert property ($changed(pip2_width) |-> $past(w2_hi) || $past(w2_hi, 2))
        else $error("pip2 width changed without a set two write");
    a_scan_forces_off: assert property (vertical_scan_direction && $past(vertical_scan_direction)
        && $past(vertical_scan_direction, 2) |-> !graphic_cursor_on)
        else $error("graphic cursor shown during flipped scan");
    a_cursor_priority: assert property (graphic_cursor_on && $past(graphic_cursor_on)
        |-> !text_cursor_on)
        else $error("text cursor on beside graphic cursor");
    a_visible_needs_on: assert property (text_cursor_visible |-> text_cursor_on || $past(text_cursor_on))
        else $error("text cursor visible while disabled");
    a_linear_zeroes: assert property (canvas_linear_mode && $past(canvas_linear_mode)
        && $past(canvas_linear_mode, 2) |-> canvas_base == 32'h0000_0000
        && canvas_width == 14'h0000 && aw_width == 14'h0000)
        else $error("canvas geometry live in linear mode");
    a_rdata_holds: assert property (!reg_re |=> $stable(reg_rdata))
        else $error("read data moved without a read");
    a_unmapped_zero: assert property (reg_re && (reg_addr < 8'h36 || reg_addr > 8'h5b
        || (reg_addr > 8'h45 && reg_addr < 8'h50)) |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_hi13_zero: assert property (reg_re && reg_addr inside {8'h37, 8'h3e, 8'h3f, 8'h41, 8'h43,
        8'h57, 8'h59} |=> reg_rdata[7:5] == 3'b000)
        else $error("unused top bits read nonzero");
    a_hi14_zero: assert property (reg_re && reg_addr inside {8'h39, 8'h3b, 8'h55, 8'h5b}
        |=> reg_rdata[7:6] == 2'b00)
        else $error("unused top two bits read nonzero");
endmodule // pcw_regs_monitor

bind pcw_regs pcw_regs_monitor mon_u (.clk, .rstn, .reg_addr, .reg_we, .reg_re, .reg_rdata,
    .pip_window_select, .vertical_scan_direction, .canvas_linear_mode, .pip1_width,
    .pip2_width, .graphic_cursor_on, .text_cursor_on, .text_cursor_visible, .canvas_base,
    .canvas_width, .aw_width);
`default_nettype wire

// ==== pcw_host.sv ====
// Host model of the byte register link: one-cycle write and read strobes.
// Assumes the bank answers a read on the cycle after the taking edge.
`default_nettype none

module pcw_host (
    // Clock
    input wire logic clk,
    // Register port
    output var logic [7:0] reg_addr,
    output var logic [7:0] reg_wdata,
    output var logic reg_we,
    output var logic reg_re,
    input wire logic [7:0] reg_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    initial {reg_addr, reg_wdata, reg_we, reg_re} = 18'h0_0000;
    // Released lines show the inverse so stale values are not mistaken for data
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_we <= 1'b1;
        @(posedge clk);
        reg_we <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_re <= 1'b1;
        @(posedge clk);
        reg_re <= 1'b0;
        reg_addr <= ~a;
        #1;
        d = reg_rdata;
    endtask
endmodule // pcw_host
`default_nettype wire

// ==== pcw_regs_bench.sv ====
// Self-checking bench for the PIP / cursor / canvas register bank.
// Assumes pcw_host drives the register port and the monitor is bound in.
`default_nettype none

module pcw_regs_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic pip_window_select = 1'b0, vertical_scan_direction = 1'b0;
    logic canvas_linear_mode = 1'b0, frame_tick = 1'b0;
    logic [1:0] char_enlarge = 2'b00;
    wire logic [7:0] reg_addr, reg_wdata, reg_rdata, cursor_colour_a, cursor_colour_b;
    wire logic [7:0] text_cursor_width_px, text_cursor_height_px;
    wire logic reg_we, reg_re, gamma_enable, gamma_table_valid, graphic_cursor_on;
    wire logic text_cursor_on, text_cursor_visible;
    wire logic [1:0] gamma_table_sel, graphic_cursor_set;
    wire logic [12:0] pip1_origin_y, pip2_origin_y, graphic_cursor_x_pos, graphic_cursor_y_pos;
    wire logic [12:0] aw_origin_x, aw_origin_y;
    wire logic [13:0] pip1_width, pip1_height, pip2_width, pip2_height, canvas_width, aw_width;
    wire logic [31:0] canvas_base;
    int num_errors = 0;
    int cmp_count = 0;
    // Rows: offset, written byte, byte read back; low bytes precede high bytes
    logic [23:0] rows [0:29] = '{24'h36_0404, 24'h37_e101, 24'h38_f8f8, 24'h39_df1f,
        24'h3a_0000, 24'h3b_c808, 24'h3c_a5a5, 24'h3d_ffff, 24'h3e_ff1f, 24'h3f_e303,
        24'h40_3434, 24'h41_ff1f, 24'h42_7878, 24'h43_e202, 24'h44_e3e3, 24'h45_1c1c,
        24'h50_fcfc, 24'h51_a5a5, 24'h52_5a5a, 24'h53_8181, 24'h54_4040, 24'h55_c707,
        24'h56_1010, 24'h57_e101, 24'h58_2020, 24'h59_ff1f, 24'h5a_0000, 24'h5b_4a0a,
        24'h46_7700, 24'h35_5500};

    pcw_regs dut_u (.clk, .rstn, .reg_addr, .reg_wdata, .reg_we, .reg_re, .reg_rdata,
        .pip_window_select, .vertical_scan_direction, .canvas_linear_mode, .char_enlarge,
        .frame_tick, .pip1_origin_y, .pip1_width, .pip1_height, .pip2_origin_y,
        .pip2_width, .pip2_height, .gamma_enable, .gamma_table_sel, .gamma_table_valid,
        .graphic_cursor_on, .graphic_cursor_set, .text_cursor_on, .text_cursor_visible,
        .text_cursor_width_px, .text_cursor_height_px, .graphic_cursor_x_pos,
        .graphic_cursor_y_pos, .cursor_colour_a, .cursor_colour_b, .canvas_base,
        .canvas_width, .aw_origin_x, .aw_origin_y, .aw_width);
    pcw_host host_u (.clk, .reg_addr, .reg_wdata, .reg_we, .reg_re, .reg_rdata);

    always #5 clk = ~clk;

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: %s", $time, msg);
        end
    endtask
    task automatic end_of_test();
        if (num_errors == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        end_of_test();
    end

    initial begin
        logic [7:0] a, d, e, r;
        logic last;
        int n, k;
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        for (int p = 0; p < 3; p++) begin
            for (int i = 0; i < 30; i++) begin
                {a, d, e} = rows[i];
                if (p == 1)
                    host_u.wr(a, d);
                else begin
                    host_u.rd(a, r);
                    chk(r, p == 0 ? (a == 8'h3e ? 8'h07 : 8'h00) : e, "read back");
                end
            end
        end
        cyc(3);
        chk({pip1_width, pip1_height}, {14'h1ff8, 14'h0800}, "pip size");
        chk(pip1_origin_y, 13'h0104, "pip origin");
        chk({graphic_cursor_x_pos, graphic_cursor_y_pos}, {13'h1f34, 13'h0278}, "gpos");
        chk({cursor_colour_a, cursor_colour_b}, 16'he31c, "colours");
        chk(canvas_base, 32'h815a_a5fc, "canvas base");
        chk({canvas_width, aw_width}, {14'h0740, 14'h0a00}, "widths");
        chk({aw_origin_x, aw_origin_y}, {13'h0110, 13'h1f20}, "aw origin");
        chk({text_cursor_width_px, text_cursor_height_px}, 16'h2004, "cursor size");
        @(posedge clk) char_enlarge <= 2'b11;
        cyc(3);
        chk({text_cursor_width_px, text_cursor_height_px}, 16'h8010, "enlarged");
        @(posedge clk) char_enlarge <= 2'b00;
        @(posedge clk) pip_window_select <= 1'b1;
        host_u.wr(8'h38, 8'h40);
        host_u.wr(8'h39, 8'h01);
        host_u.wr(8'h37, 8'h02);
        host_u.wr(8'h3b, 8'h03);
        @(posedge clk) pip_window_select <= 1'b0;
        host_u.wr(8'h38, 8'h8c);
        cyc(3);
        chk({pip1_width, pip2_width}, {14'h1ff8, 14'h0140}, "pip steer");
        chk({pip2_origin_y, pip2_height}, {13'h0204, 14'h0300}, "pip2 set");
        chk({pip1_origin_y, pip1_height}, {13'h0104, 14'h0800}, "pip1 kept");
        host_u.wr(8'h39, 8'h00);
        cyc(3);
        chk(pip1_width, 14'h0088, "pip step");
        @(posedge clk) canvas_linear_mode <= 1'b1;
        cyc(3);
        chk({canvas_base[3:0], canvas_width, aw_width}, 32'h0000_0000, "linear");
        chk(canvas_base, 32'h0000_0000, "linear base");
        chk({aw_origin_x, aw_origin_y}, 26'h000_0000, "linear origin");
        host_u.rd(8'h50, r);
        chk(r, 8'hfc, "linear keeps");
        @(posedge clk) canvas_linear_mode <= 1'b0;
        for (int c = 0; c < 4; c++) begin
            host_u.wr(8'h3c, {c[0], c[1:0], 1'b0, c[1:0], 2'b00});
            cyc(3);
            chk({gamma_enable, gamma_table_sel, gamma_table_valid, graphic_cursor_set},
                {c[0], c[1:0], c != 3, c[1:0]}, "codes");
        end
        host_u.wr(8'h3c, 8'h12);
        cyc(3);
        chk({graphic_cursor_on, text_cursor_on}, 2'b10, "priority");
        @(posedge clk) vertical_scan_direction <= 1'b1;
        cyc(3);
        chk({graphic_cursor_on, text_cursor_on, text_cursor_visible}, 3'b011, "scan");
        @(posedge clk) vertical_scan_direction <= 1'b0;
        host_u.wr(8'h3d, 8'h02);
        host_u.wr(8'h3c, 8'h03);
        cyc(3);
        last = text_cursor_visible;
        n = 0;
        k = 0;
        for (int t = 1; t <= 12; t++) begin
            @(posedge clk) frame_tick <= 1'b1;
            @(posedge clk) frame_tick <= 1'b0;
            cyc(2);
            if (text_cursor_visible !== last) begin
                if (n > 0)
                    chk(t - k, 3, "blink period");
                n++;
                k = t;
                last = text_cursor_visible;
            end
        end
        chk(n >= 3, 1, "blink toggles");
        @(posedge clk) rstn <= 1'b0;
        cyc(2);
        chk({gamma_enable, text_cursor_on, reg_rdata}, 0, "in reset");
        @(posedge clk) rstn <= 1'b1;
        host_u.rd(8'h3e, r);
        chk({r, text_cursor_width_px, text_cursor_height_px}, 24'h07_0801, "size reset");
        end_of_test();
    end
endmodule // pcw_regs_bench
`default_nettype wire
